// ---- twsch_pkg.sv ----
// package: register map, field layout, timing and states of the two-wire slave
package twsch_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_DATA = 8'h00;
   localparam logic [7:0] OFS_LEVEL = 8'h04;
   localparam logic [7:0] OFS_CMD = 8'h08;
   localparam logic [7:0] OFS_CFG = 8'h0C;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_MASK = 8'h14;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // slave_config fields
   localparam int CFG_ADDR_LSB = 9;
   localparam int CFG_TX4 = 4;
   localparam int CFG_EXT_OFF = 3;
   localparam int CFG_LOW_OFF = 2;
   localparam int CFG_NACK_SEL = 1;
   localparam int CFG_HS_OFF = 0;
   localparam logic [15:0] CFG_RESET = 16'h1600;
   localparam logic [15:0] CFG_WMASK = 16'hFE1F;
   // slave_command_latch and slave_fifo_level fields
   localparam int CMD_BUSY_BIT = 8;
   localparam int LVL_TX_LSB = 4;
   // slave_irq_status bits
   localparam int IRQ_RX_FULL = 0;
   localparam int IRQ_RX_EMPTY = 1;
   localparam int IRQ_RX_BYTE = 2;
   localparam int IRQ_CMD = 3;
   localparam int IRQ_TX_FULL = 4;
   localparam int IRQ_TX_EMPTY = 5;
   localparam int IRQ_TX_BYTE = 6;
   localparam int IRQ_START = 7;
   localparam int IRQ_RESTART_W = 8;
   localparam int IRQ_RESTART_R = 9;
   localparam int IRQ_STOP = 10;
   localparam int IRQ_TIMEOUT = 11;
   localparam int IRQ_N = 12;
   localparam logic [11:0] IRQ_EDGE = 12'hFDE;
   // buffers and bytes
   localparam int FIFO_DEPTH = 8;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   // timing
   localparam int CLK_KHZ = 100000;
   localparam int CLK_NS = 10;
   localparam int EXT_LIMIT_MS = 15;
   localparam int LOW_LIMIT_MS = 30;
   localparam int EXT_LIMIT_CYC = EXT_LIMIT_MS * CLK_KHZ;
   localparam int LOW_LIMIT_CYC = LOW_LIMIT_MS * CLK_KHZ;
   localparam int LONG_FACTOR = 4;
   localparam int TO_W = 24;
   localparam int REL_DELAY_NS = 1000;
   localparam logic [7:0] REL_LAST = 8'(REL_DELAY_NS / CLK_NS - 1);
   // bus engine states
   typedef enum logic [9:0] {
      ST_IDLE = 10'h001,
      ST_ADDR = 10'h002,
      ST_AACK = 10'h004,
      ST_RX = 10'h008,
      ST_RDEC = 10'h010,
      ST_RACK = 10'h020,
      ST_TDEC = 10'h040,
      ST_TX = 10'h080,
      ST_TACK = 10'h100,
      ST_TOUT = 10'h200
   } twsch_state_t;
endpackage : twsch_pkg

// ---- twsch_fifo_if.sv ----
// interface: signals between the bus engine and one byte queue
`timescale 1ns/1ps
interface twsch_fifo_if #(parameter int W = 8, parameter int AW = 3);
   logic push;
   logic pop;
   logic flush;
   logic full;
   logic empty;
   logic [W-1:0] pushData;
   logic [W-1:0] popData;
   logic [AW:0] level;
   modport mem (input push, pop, flush, pushData, output popData, level, full, empty);
   modport user (output push, pop, flush, pushData, input popData, level, full, empty);
endinterface : twsch_fifo_if

// ---- twsch_fifo.sv ----
// byte queue with registered read data
`timescale 1ns/1ps
module twsch_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic clock,
   input wire logic srst,
   twsch_fifo_if.mem port
);
   import twsch_pkg::*;

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wrPtr;
      logic [AW-1:0] rdPtr;
      logic [AW:0] count;
      logic [W-1:0] popData;
   } twsch_fifo_st_t;

   twsch_fifo_st_t r;
   twsch_fifo_st_t next_r;
   logic doPush;
   logic doPop;

   // push refused when full, pop refused when empty, flush wins
   always_comb begin
      next_r = r;
      doPush = port.push && !port.full;
      doPop = port.pop && !port.empty;
      if (port.flush) begin
         next_r.wrPtr = '0;
         next_r.rdPtr = '0;
         next_r.count = '0;
      end else begin
         if (doPush) begin
            next_r.mem[r.wrPtr] = port.pushData;
            next_r.wrPtr = r.wrPtr + 1'b1;
         end
         if (doPop) begin
            next_r.popData = r.mem[r.rdPtr];
            next_r.rdPtr = r.rdPtr + 1'b1;
         end
         next_r.count = r.count + (AW+1)'(doPush) - (AW+1)'(doPop);
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // status flags from the count
   assign port.full = (r.count == (AW+1)'(DEPTH));
   assign port.empty = (r.count == '0);
   assign port.level = r.count;
   assign port.popData = r.popData;

   a_fifo_bound: assert property (@(posedge clock) disable iff (srst) r.count <= (AW+1)'(DEPTH))
      else $error("fifo count beyond depth");
endmodule : twsch_fifo

// ---- twsch_top.sv ----
// two-wire slave: AHB-Lite registers, bus engine, command handshake, timeouts
`timescale 1ns/1ps
// How it works
// - address in bits 15:9, 8:5 read zero
// - bit 4 lengthens both timeouts fourfold
// - bit 3 disables the extend timeout
// - bit 2 disables the clock-low timeout
// - busy latch, stretch mode: hold SCL low
// - busy latch, nack mode: refuse command byte
// - bit 0 set accepts every command byte
// - stretching and acking done by hardware alone
// - hardware handles both bus timeouts itself
// - first write byte after a non-repeated start address is command
// - command byte stays readable by software
// - handshake off: always store and ack
// - handshake on: accepted command sets busy
// - command latch write clears busy, unless a command is taken that cycle
// - events in status register, gated by mask
// - data port and fifo level registers
// - eight byte receive and transmit queues
// - accepted command flushes both queues
// - clock-low counter, release SCL then SDA
// - extend counter counts own stretching only
module twsch_top #(
   parameter int EXT_CYCLES = twsch_pkg::EXT_LIMIT_CYC,
   parameter int LOW_CYCLES = twsch_pkg::LOW_LIMIT_CYC,
   parameter int FIFO_DEPTH = twsch_pkg::FIFO_DEPTH
) (
   input wire logic clock,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   output logic irq
);
   import twsch_pkg::*;

   localparam int AW = $clog2(FIFO_DEPTH);

   typedef struct packed {
      logic [1:0] sclSy;
      logic [1:0] sdaSy;
      logic sclP;
      logic sdaP;
      twsch_state_t st;
      logic [7:0] shift;
      logic [3:0] bitCnt;
      logic rw;
      logic rep;
      logic active;
      logic cmdNext;
      logic acked;
      logic loaded;
      logic [7:0] cmd;
      logic busy;
      logic [15:0] cfg;
      logic [IRQ_N-1:0] irqStat;
      logic [IRQ_N-1:0] irqMask;
      logic rxEmptyP;
      logic txFullP;
      logic [TO_W-1:0] lowCnt;
      logic [TO_W-1:0] extCnt;
      logic lowFired;
      logic [7:0] relCnt;
      logic aPend;
      logic aWrite;
      logic [7:0] aAddr;
      logic readyOut;
      logic [31:0] rdata;
      logic sclOe;
      logic sdaOe;
      logic irq;
   } twsch_reg_t;

   twsch_reg_t r;
   twsch_reg_t next_r;

   logic sclS, sdaS, rise, fall, evStart, evStop;
   logic hsOff, nackSel, lowFire, extFire, toHit, abortNow, cmdTake, aTake;
   logic [TO_W-1:0] lowLim, extLim;
   logic rxPush, txPush, txPop, flushAll;
   logic [IRQ_N-1:0] evt;

   twsch_fifo_if #(.W(8), .AW(AW)) rxIf ();
   twsch_fifo_if #(.W(8), .AW(AW)) txIf ();

   twsch_fifo #(.W(8), .DEPTH(FIFO_DEPTH), .AW(AW)) rxFifo (
      .clock(clock),
      .srst(srst),
      .port(rxIf)
   );
   twsch_fifo #(.W(8), .DEPTH(FIFO_DEPTH), .AW(AW)) txFifo (
      .clock(clock),
      .srst(srst),
      .port(txIf)
   );

   // word register select on the low address byte
   function automatic logic isReg(input logic [7:0] addr, input logic [7:0] ofs);
      return addr == ofs;
   endfunction : isReg

   // timeout limit, fourfold when lengthened
   function automatic logic [TO_W-1:0] limitFor(input int base, input logic long4);
      return long4 ? TO_W'(base * LONG_FACTOR) : TO_W'(base);
   endfunction : limitFor

   // bus conditions seen through the synchronisers
   assign sclS = r.sclSy[1];
   assign sdaS = r.sdaSy[1];
   assign rise = sclS && !r.sclP;
   assign fall = !sclS && r.sclP;
   assign evStart = sclS && r.sclP && r.sdaP && !sdaS;
   assign evStop = sclS && r.sclP && !r.sdaP && sdaS;

   // configuration decode and timeout detection
   assign hsOff = r.cfg[CFG_HS_OFF];
   assign nackSel = r.cfg[CFG_NACK_SEL];
   assign lowLim = limitFor(LOW_CYCLES, r.cfg[CFG_TX4]);
   assign extLim = limitFor(EXT_CYCLES, r.cfg[CFG_TX4]);
   assign lowFire = !r.cfg[CFG_LOW_OFF] && !sclS && (r.lowCnt >= lowLim) && !r.lowFired
      && (r.st != ST_IDLE) && (r.st != ST_TOUT);
   assign extFire = !r.cfg[CFG_EXT_OFF] && r.sclOe && (r.extCnt >= extLim);
   assign toHit = lowFire || extFire;
   assign abortNow = toHit || ((evStart || evStop) && (r.st != ST_TOUT));
   assign cmdTake = (r.st == ST_RDEC) && r.cmdNext && (hsOff || !r.busy) && !abortNow;

   // address phase taken only when idle and word sized
   assign aTake = hsel && htrans[1] && hready && r.readyOut && (hsize == HSIZE_WORD);

   // queue connections
   assign rxIf.push = rxPush;
   assign rxIf.pushData = r.shift;
   assign rxIf.pop = aTake && !hwrite && isReg(haddr[7:0], OFS_DATA);
   assign rxIf.flush = flushAll;
   assign txIf.push = txPush;
   assign txIf.pushData = hwdata[7:0];
   assign txIf.pop = txPop;
   assign txIf.flush = flushAll;

   // next state of the whole block
   always_comb begin
      next_r = r;
      rxPush = 1'b0;
      txPush = 1'b0;
      txPop = 1'b0;
      flushAll = 1'b0;
      evt = '0;
      next_r.sclSy = {r.sclSy[0], sclIn};
      next_r.sdaSy = {r.sdaSy[0], sdaIn};
      next_r.sclP = sclS;
      next_r.sdaP = sdaS;
      // register bus: one wait state per transfer
      next_r.readyOut = 1'b1;
      next_r.aPend = 1'b0;
      if (aTake) begin
         next_r.aPend = 1'b1;
         next_r.aWrite = hwrite;
         next_r.aAddr = haddr[7:0];
         next_r.readyOut = 1'b0;
      end
      if (r.aPend && r.aWrite) begin
         txPush = isReg(r.aAddr, OFS_DATA);
         if (isReg(r.aAddr, OFS_CMD)) next_r.busy = 1'b0;
         if (isReg(r.aAddr, OFS_CFG)) next_r.cfg = hwdata[15:0] & CFG_WMASK;
         if (isReg(r.aAddr, OFS_STAT)) begin
            next_r.irqStat = r.irqStat & (hwdata[IRQ_N-1:0] | ~IRQ_EDGE);
         end
         if (isReg(r.aAddr, OFS_MASK)) next_r.irqMask = hwdata[IRQ_N-1:0];
      end
      if (r.aPend && !r.aWrite) begin
         next_r.rdata = '0;
         if (isReg(r.aAddr, OFS_DATA)) next_r.rdata[7:0] = rxIf.popData;
         if (isReg(r.aAddr, OFS_LEVEL)) begin
            next_r.rdata[AW:0] = rxIf.level;
            next_r.rdata[LVL_TX_LSB +: AW+1] = txIf.level;
         end
         if (isReg(r.aAddr, OFS_CMD)) next_r.rdata[CMD_BUSY_BIT:0] = {r.busy, r.cmd};
         if (isReg(r.aAddr, OFS_CFG)) next_r.rdata[15:0] = r.cfg;
         if (isReg(r.aAddr, OFS_STAT)) next_r.rdata[IRQ_N-1:0] = r.irqStat;
         if (isReg(r.aAddr, OFS_MASK)) next_r.rdata[IRQ_N-1:0] = r.irqMask;
      end
      // clock-low counter runs while SCL low, extend counter while we hold it
      next_r.lowCnt = sclS ? '0 : ((r.lowCnt >= lowLim) ? r.lowCnt : r.lowCnt + 1'b1);
      if (sclS) next_r.lowFired = 1'b0;
      if (r.sclOe && (r.extCnt < extLim)) next_r.extCnt = r.extCnt + 1'b1;
      // shift in data bits on SCL rise
      if (rise && ((r.st == ST_ADDR) || (r.st == ST_RX))) begin
         next_r.shift = {r.shift[6:0], sdaS};
         next_r.bitCnt = r.bitCnt + 1'b1;
      end
      // bus engine
      if (toHit) begin
         next_r.st = ST_TOUT;
         next_r.relCnt = '0;
         next_r.active = 1'b0;
         next_r.cmdNext = 1'b0;
         next_r.lowFired = 1'b1;
         evt[IRQ_TIMEOUT] = 1'b1;
      end else if (evStart && (r.st != ST_TOUT)) begin
         next_r.st = ST_ADDR;
         next_r.bitCnt = '0;
         next_r.sdaOe = 1'b0;
         next_r.rep = r.active;
         if (!r.active) next_r.extCnt = '0;
      end else if (evStop && (r.st != ST_TOUT)) begin
         next_r.st = ST_IDLE;
         next_r.sdaOe = 1'b0;
         next_r.active = 1'b0;
         next_r.cmdNext = 1'b0;
         evt[IRQ_STOP] = r.active;
      end else begin
         unique case (r.st)
            ST_IDLE: begin
               next_r.sdaOe = 1'b0;
            end
            ST_ADDR: begin
               if (fall && (r.bitCnt == BYTE_BITS)) begin
                  if (r.shift[7:1] == r.cfg[CFG_ADDR_LSB +: 7]) begin
                     next_r.st = ST_AACK;
                     next_r.sdaOe = 1'b1;
                     next_r.active = 1'b1;
                     next_r.rw = r.shift[0];
                     next_r.cmdNext = !r.shift[0] && !r.rep;
                     evt[IRQ_START] = !r.rep;
                     evt[IRQ_RESTART_W] = r.rep && !r.shift[0];
                     evt[IRQ_RESTART_R] = r.rep && r.shift[0];
                  end else begin
                     next_r.st = ST_IDLE;
                  end
               end
            end
            ST_AACK: begin
               if (fall) begin
                  next_r.sdaOe = 1'b0;
                  next_r.bitCnt = '0;
                  next_r.loaded = 1'b0;
                  next_r.st = r.rw ? ST_TDEC : ST_RX;
               end
            end
            ST_RX: begin
               if (fall && (r.bitCnt == BYTE_BITS)) next_r.st = ST_RDEC;
            end
            ST_RDEC: begin
               if (r.cmdNext) begin
                  if (cmdTake) begin
                     next_r.cmd = r.shift;
                     next_r.busy = !hsOff;
                     next_r.cmdNext = 1'b0;
                     flushAll = 1'b1;
                     evt[IRQ_CMD] = 1'b1;
                     next_r.sdaOe = 1'b1;
                     next_r.st = ST_RACK;
                  end else if (!hsOff && nackSel) begin
                     next_r.st = ST_RACK;
                  end
               end else if (!rxIf.full) begin
                  rxPush = 1'b1;
                  evt[IRQ_RX_BYTE] = 1'b1;
                  next_r.sdaOe = 1'b1;
                  next_r.st = ST_RACK;
               end
            end
            ST_RACK: begin
               if (fall) begin
                  next_r.sdaOe = 1'b0;
                  next_r.bitCnt = '0;
                  next_r.st = ST_RX;
               end
            end
            ST_TDEC: begin
               if (!r.loaded) begin
                  txPop = !txIf.empty;
                  next_r.loaded = !txIf.empty;
               end else begin
                  next_r.shift = txIf.popData;
                  next_r.sdaOe = !txIf.popData[7];
                  next_r.bitCnt = '0;
                  next_r.loaded = 1'b0;
                  evt[IRQ_TX_BYTE] = 1'b1;
                  next_r.st = ST_TX;
               end
            end
            ST_TX: begin
               if (fall && (r.bitCnt == LAST_BIT)) begin
                  next_r.sdaOe = 1'b0;
                  next_r.st = ST_TACK;
               end else if (fall) begin
                  next_r.shift = {r.shift[6:0], 1'b0};
                  next_r.sdaOe = !r.shift[6];
                  next_r.bitCnt = r.bitCnt + 1'b1;
               end
            end
            ST_TACK: begin
               if (rise) next_r.acked = !sdaS;
               if (fall) next_r.st = r.acked ? ST_TDEC : ST_IDLE;
            end
            ST_TOUT: begin
               if (r.relCnt == REL_LAST) begin
                  next_r.sdaOe = 1'b0;
                  next_r.st = ST_IDLE;
               end else begin
                  next_r.relCnt = r.relCnt + 1'b1;
               end
            end
            default: begin
               next_r.st = ST_IDLE;
            end
         endcase
      end
      // hold SCL while deciding, and one cycle more so SDA settles first
      next_r.sclOe = (next_r.st == ST_RDEC) || (next_r.st == ST_TDEC)
         || (((r.st == ST_RDEC) || (r.st == ST_TDEC))
         && ((next_r.st == ST_RACK) || (next_r.st == ST_TX)));
      // status: edge bits sticky with set over clear, level bits live
      evt[IRQ_RX_EMPTY] = rxIf.empty && !r.rxEmptyP;
      evt[IRQ_TX_FULL] = txIf.full && !r.txFullP;
      next_r.rxEmptyP = rxIf.empty;
      next_r.txFullP = txIf.full;
      next_r.irqStat = next_r.irqStat | (evt & IRQ_EDGE);
      next_r.irqStat[IRQ_RX_FULL] = rxIf.full;
      next_r.irqStat[IRQ_TX_EMPTY] = txIf.empty;
      next_r.irq = |(r.irqStat & r.irqMask);
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         r <= '0;
         r.sclSy <= 2'h3;
         r.sdaSy <= 2'h3;
         r.sclP <= 1'b1;
         r.sdaP <= 1'b1;
         r.st <= ST_IDLE;
         r.cfg <= CFG_RESET;
         r.readyOut <= 1'b1;
         r.rxEmptyP <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from the state register or tied low
   assign hreadyout = r.readyOut;
   assign hresp = 1'b0;
   assign hrdata = r.rdata;
   assign sclOut = 1'b0;
   assign sdaOut = 1'b0;
   assign sclOe = r.sclOe;
   assign sdaOe = r.sdaOe;
   assign irq = r.irq;

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   a_cfg_reserved: assert property (r.cfg[8:5] == 4'h0)
      else $error("reserved config bits not zero");
   a_limit_value: assert property (lowFire |-> r.lowCnt
      == (r.cfg[CFG_TX4] ? TO_W'(LOW_CYCLES * 4) : TO_W'(LOW_CYCLES)))
      else $error("clock-low limit wrong");
   a_ext_own_hold: assert property (!r.sclOe && !evStart |=> $stable(r.extCnt))
      else $error("extend counter moved without own stretch");
   a_stretch_busy: assert property ((r.st == ST_RDEC) && r.cmdNext && r.busy && !hsOff
      && !nackSel && !abortNow |=> (r.st == ST_RDEC) && r.sclOe)
      else $error("busy command not stretched");
   a_nack_busy: assert property ((r.st == ST_RDEC) && r.cmdNext && r.busy && !hsOff
      && nackSel && !abortNow |=> (r.st == ST_RACK) && !r.sdaOe ##1 !r.sclOe)
      else $error("busy command not refused");
   a_hs_off_ack: assert property ((r.st == ST_RDEC) && r.cmdNext && hsOff && !abortNow
      |=> r.sdaOe && !r.busy && (r.cmd == $past(r.shift)))
      else $error("command not taken with handshake off");
   a_accept_flush: assert property (cmdTake && !hsOff
      |=> r.busy && (rxIf.level == '0) && (txIf.level == '0))
      else $error("accepted command did not set busy and flush");
   a_busy_clear: assert property (r.aPend && r.aWrite && isReg(r.aAddr, OFS_CMD) && !cmdTake
      |=> !r.busy)
      else $error("command latch write did not clear busy");
   a_first_cmd: assert property ((r.st == ST_ADDR) && fall && (r.bitCnt == BYTE_BITS)
      && (r.shift[7:1] == r.cfg[CFG_ADDR_LSB +: 7]) && !r.shift[0] && !r.rep
      |=> r.cmdNext && r.sdaOe)
      else $error("first write byte not marked as command");
   a_addr_ignore: assert property ((r.st == ST_ADDR) && fall && (r.bitCnt == BYTE_BITS)
      && (r.shift[7:1] != r.cfg[CFG_ADDR_LSB +: 7]) && !abortNow
      |=> (r.st == ST_IDLE) && !r.sdaOe)
      else $error("foreign address answered");
   a_timeout_release: assert property (toHit |=> (r.st == ST_TOUT) && !r.sclOe
      ##[1:200] ((r.st == ST_IDLE) && !r.sdaOe))
      else $error("timeout did not release the bus");
   a_irq_gate: assert property (##1 (r.irq == |($past(r.irqStat) & $past(r.irqMask))))
      else $error("interrupt output not gated by mask");

   c_cmd_taken: cover property (cmdTake);
   c_cmd_nacked: cover property ((r.st == ST_RDEC) && r.cmdNext && r.busy && nackSel);
   c_timeout: cover property (toHit);
   c_tx_byte: cover property ((r.st == ST_TACK) && fall && r.acked);
endmodule : twsch_top

// ---- twsch_i2c_master.sv ----
// two-wire bus master model with open-drain wires and pull-ups
`timescale 1ns/1ps
module twsch_i2c_master (
   input wire logic sclOe,
   input wire logic sdaOe,
   output logic sclIn,
   output logic sdaIn
);
   localparam realtime Q = 31.25;
   logic sclPull = 1'b0;
   logic sdaPull = 1'b0;
   // wired-and of both parties, pulled high when released
   assign sclIn = !(sclPull || sclOe);
   assign sdaIn = !(sdaPull || sdaOe);
   // one bit: data set in low phase, clock waits out any stretching
   task automatic clockBit(input logic drive, output logic seen);
      #Q;
      sdaPull = !drive;
      #Q;
      sclPull = 1'b0;
      wait (sclIn === 1'b1);
      #Q;
      seen = sdaIn;
      #Q;
      sclPull = 1'b1;
   endtask : clockBit
   task automatic startCond();
      sclPull = 1'b0;
      #(2 * Q);
      sdaPull = 1'b1;
      #(2 * Q);
      sclPull = 1'b1;
   endtask : startCond
   task automatic stopCond();
      #Q;
      sdaPull = 1'b1;
      #Q;
      sclPull = 1'b0;
      wait (sclIn === 1'b1);
      #Q;
      sdaPull = 1'b0;
      #(4 * Q);
   endtask : stopCond
   // msb first, then the acknowledge slot with sda released
   task automatic sendByte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clockBit(b[i], s);
      clockBit(1'b1, s);
      ack = !s;
   endtask : sendByte
   // eight bits read with sda released, then ack driven low or nack left high
   task automatic recvByte(input logic last, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clockBit(1'b1, s);
         b[i] = s;
      end
      clockBit(last, s);
   endtask : recvByte
endmodule : twsch_i2c_master

// ---- testbench.sv ----
// testbench: register and two-wire scenarios for the slave block
`timescale 1ns/1ps
module testbench;
   import twsch_pkg::*;
   localparam int LOW_CYC = 800;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = HSIZE_WORD;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, sclIn, sclOut, sclOe, sdaIn, sdaOut, sdaOe, irq;
   logic [31:0] hrdata;
   int fail_count = 0;
   int check_count = 0;
   always #5 clock = ~clock;
   twsch_top #(.EXT_CYCLES(400), .LOW_CYCLES(LOW_CYC)) uut (.clock(clock), .srst(srst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaIn),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .irq(irq));
   twsch_i2c_master master (.sclOe(sclOe), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // single ahb transfer: hold address until hready, then data until hready
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
         output logic [31:0] rd);
      @(posedge clock);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      ahb(a, 1'b1, d, rd);
   endtask : wr
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e,
         input logic [31:0] m = 32'hFFFFFFFF);
      logic [31:0] rd;
      ahb(a, 1'b0, 32'h0, rd);
      check(rd & m, e);
      check({29'h0, hresp, sclOut, sdaOut}, 32'h0);
   endtask : rdChk
   task automatic i2cByte(input logic [7:0] b, input logic expAck);
      logic ack;
      master.sendByte(b, ack);
      check({31'h0, ack}, {31'h0, expAck});
   endtask : i2cByte
   task automatic i2cRead(input logic [7:0] e, input logic last);
      logic [7:0] b;
      master.recvByte(last, b);
      check({24'h0, b}, {24'h0, e});
   endtask : i2cRead
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   // watchdog against a hung handshake or stretched bus
   initial begin
      #300us;
      fail_count++;
      end_sim();
   end
   // main sequence
   initial begin
      repeat (4) @(posedge clock);
      srst <= 1'b0;
      repeat (3) @(posedge clock);
      rdChk(OFS_CFG, 32'h1600);
      wr(OFS_CFG, 32'hFFFF);
      rdChk(OFS_CFG, 32'hFE1F);
      wr(OFS_CFG, 32'h1602);
      master.startCond();
      i2cByte(8'h18, 1'b0);
      master.stopCond();
      master.startCond();
      i2cByte(8'h16, 1'b1);
      i2cByte(8'hA5, 1'b1);
      i2cByte(8'h3C, 1'b1);
      master.stopCond();
      rdChk(OFS_CMD, 32'h1A5);
      rdChk(OFS_LEVEL, 32'h1);
      // busy latch refuses, release, master resends
      master.startCond();
      i2cByte(8'h16, 1'b1);
      i2cByte(8'h5A, 1'b0);
      wr(OFS_CMD, 32'h0);
      i2cByte(8'h5A, 1'b1);
      master.stopCond();
      rdChk(OFS_CMD, 32'h15A);
      rdChk(OFS_LEVEL, 32'h0);
      // busy latch in stretch mode holds the clock until released
      wr(OFS_CFG, 32'h1600);
      master.startCond();
      i2cByte(8'h16, 1'b1);
      fork
         i2cByte(8'h77, 1'b1);
         begin
            repeat (150) @(posedge clock);
            check({31'h0, sclOe}, 32'h1);
            wr(OFS_CMD, 32'h0);
         end
      join
      master.stopCond();
      rdChk(OFS_CMD, 32'h177);
      // handshake off: first command taken while busy, second taken with busy clear
      wr(OFS_CFG, 32'h1601);
      for (int i = 1; i < 3; i++) begin
         master.startCond();
         i2cByte(8'h16, 1'b1);
         i2cByte(8'(i * 17), 1'b1);
         master.stopCond();
         rdChk(OFS_CMD, 32'(i * 17), 32'hFF);
      end
      // clock held low by master: normal, disabled, lengthened limit
      for (int i = 0; i < 3; i++) begin
         wr(OFS_STAT, 32'h0);
         wr(OFS_CFG, i == 0 ? 32'h1600 : (i == 1 ? 32'h1604 : 32'h1610));
         master.startCond();
         i2cByte(8'h16, 1'b1);
         repeat (LOW_CYC + 200) @(posedge clock);
         rdChk(OFS_STAT, i == 0 ? 32'h800 : 32'h0, 32'h800);
         master.stopCond();
      end
      // busy latch in stretch mode: extend limit fires, then is switched off
      wr(OFS_MASK, 32'h800);
      for (int i = 0; i < 2; i++) begin
         wr(OFS_CFG, i == 0 ? 32'h1600 : 32'h160C);
         wr(OFS_STAT, 32'h0);
         master.startCond();
         i2cByte(8'h16, 1'b1);
         i2cByte(8'h30, 1'b1);
         master.stopCond();
         master.startCond();
         i2cByte(8'h16, 1'b1);
         fork
            i2cByte(8'h31, i[0]);
            begin
               repeat (600) @(posedge clock);
               rdChk(OFS_STAT, i == 0 ? 32'h800 : 32'h0, 32'h800);
               check({31'h0, irq}, {31'h0, i == 0});
               wr(OFS_CMD, 32'h0);
            end
         join
         master.stopCond();
      end
      rdChk(OFS_CMD, 32'h131);
      rdChk(OFS_MASK, 32'h800);
      // full receive queue, then repeated start and read of two bytes
      wr(OFS_CFG, 32'h1601);
      wr(OFS_STAT, 32'h0);
      master.startCond();
      i2cByte(8'h16, 1'b1);
      i2cByte(8'h42, 1'b1);
      for (int k = 0; k < 8; k++) i2cByte(8'(k + 1), 1'b1);
      rdChk(OFS_LEVEL, 32'h8);
      rdChk(OFS_STAT, 32'h1, 32'h1);
      rdChk(OFS_DATA, 32'h1);
      wr(OFS_DATA, 32'hC3);
      wr(OFS_DATA, 32'h5A);
      rdChk(OFS_LEVEL, 32'h27);
      master.startCond();
      i2cByte(8'h17, 1'b1);
      i2cRead(8'hC3, 1'b0);
      i2cRead(8'h5A, 1'b1);
      master.stopCond();
      rdChk(OFS_STAT, 32'h240, 32'h240);
      end_sim();
   end
endmodule : testbench
